// File: cbm_pkg.sv
// Package for the CAN basic mask and interrupt logic.
// Assumes a 16-bit register port with registered read data.
package cbm_pkg;

   // ----------------------------------------------------------------
   // Register map (word indices on the register port)
   // ----------------------------------------------------------------
   localparam logic [3:0] ADDR_MASK_HIGH = 4'h0;
   localparam logic [3:0] ADDR_MASK_LOW  = 4'h1;
   localparam logic [3:0] ADDR_INT_EN    = 4'h2;
   localparam logic [3:0] ADDR_INT_PEND  = 4'h3;
   localparam logic [3:0] ADDR_INT_CLR   = 4'h4;
   localparam logic [3:0] ADDR_CODE_EN   = 4'h5;
   localparam logic [3:0] ADDR_STATUS    = 4'h6;
   localparam logic [3:0] ADDR_CONFIG    = 4'h7;

   localparam logic [15:0] RESET_WORD = 16'h0000;
   localparam int NUM_BUF = 15;
   localparam int ERR_BIT = 15;          // error bit in enable/pend/clr
   localparam int CFG_EIT_BIT = 0;       // error interrupt type

   // ----------------------------------------------------------------
   // Mask word field positions
   // ----------------------------------------------------------------
   localparam int MH_ID_HI_LSB = 5;      // id mask 28..18 in 15..5
   localparam int MH_RTR_BIT   = 4;
   localparam int MH_IDE_BIT   = 3;
   localparam int ML_EXT_REMOTE_MASK_BIT  = 0;

   // ----------------------------------------------------------------
   // Node state codes and status word layout
   // ----------------------------------------------------------------
   localparam logic [2:0] NS_NOT_ACTIVE = 3'h0;
   localparam logic [2:0] NS_ERR_ACTIVE = 3'h2;
   localparam logic [2:0] NS_WARNING    = 3'h3;
   localparam logic [2:0] NS_PASSIVE    = 3'h4;
   localparam logic [2:0] NS_BUS_OFF    = 3'h6;
   localparam logic [3:0] SRC_NONE      = 4'h0;

   // Received frame header, as seen by the acceptance filter
   typedef struct packed {
      logic        ext;      // extended frame
      logic [28:0] id;       // standard id sits in id[28:18]
      logic        srr_rtr;  // RTR (std) or SRR (ext)
      logic        ide;
      logic        ext_remote_mask;     // RTR of an extended frame
   } cbm_frame_t;

   // Status word contents
   typedef struct packed {
      logic [7:0] rsvd;
      logic [2:0] node_state;
      logic       irq;
      logic [3:0] source_code;
   } cbm_status_t;

endpackage

// File: cbm_filter.sv
// Acceptance filter of the basic mask against one buffer identifier.
// Assumes frame and buffer fields are stable in the cycle evaluated.
`timescale 1ns/1ps
module cbm_filter
   import cbm_pkg::*;
(
   // Mask words
   input  wire logic [15:0] i_mask_high,
   input  wire logic [15:0] i_mask_low,
   // Received frame and buffer identifier
   input  wire cbm_frame_t  i_frame,
   input  wire cbm_frame_t  i_buf,
   // Result
   output logic             o_match,
   output cbm_frame_t       o_new_id
);

   logic [31:0] care;    // one where the bit must match
   logic [31:0] rx_v;
   logic [31:0] bf_v;
   logic [31:0] mask_v;

   // ----------------------------------------------------------------
   // Pack to the 32-bit mask order: id28..18, rtr, ide, id17..0, ext_remote_mask
   // ----------------------------------------------------------------
   always_comb begin
      mask_v = {i_mask_high, i_mask_low};
      rx_v   = {i_frame.id[28:18], i_frame.srr_rtr, i_frame.ide,
                i_frame.id[17:0], i_frame.ext_remote_mask};
      bf_v   = {i_buf.id[28:18], i_buf.srr_rtr, i_buf.ide,
                i_buf.id[17:0], i_buf.ext_remote_mask};
      care   = ~mask_v;
      if (!i_frame.ext) begin
         care[18:0] = 19'h0_0000;
      end
      o_match = ((rx_v ^ bf_v) & care) == 32'h0000_0000;
   end

   // Don't-care bits take the received value on acceptance
   always_comb begin
      o_new_id         = i_buf;
      o_new_id.id      = i_buf.id;
      for (int k = 0; k < 11; k++) begin
         if (mask_v[31-k]) o_new_id.id[28-k] = i_frame.id[28-k];
      end
      if (mask_v[20]) o_new_id.srr_rtr = i_frame.srr_rtr;
      if (mask_v[19]) o_new_id.ide     = i_frame.ide;
      if (i_frame.ext) begin
         for (int k = 0; k < 18; k++) begin
            if (mask_v[1+k]) o_new_id.id[k] = i_frame.id[k];
         end
         if (mask_v[0]) o_new_id.ext_remote_mask = i_frame.ext_remote_mask;
      end
   end

endmodule

// File: cbm_top.sv
// Register logic: basic mask, interrupt enable/pending/clear, code
// enable and node status with priority interrupt code.
// Assumes a same-clock register master and same-clock event inputs.
//
// Contract
// - Cleared mask bit: incoming id bit must equal buffer id bit.
// - Set mask bit: don't care, buffer bit takes received value.
// - Extended frames use all 29 id mask bits plus IDE, RTR, EXT_REMOTE_MASK.
// - Extended frames: RTR mask on SRR, extended remote mask on RTR.
// - Standard frames use only mask 28..18, RTR and IDE.
// - Mask word layout: high 28..18,RTR,IDE,17..15; low 14..0,EXT_REMOTE_MASK.
// - Error interrupt reaches CPU only while enable bit 15 is one.
// - Buffer n interrupt reaches CPU only while enable bit n is one.
// - Buffer pending bit sets after successful transfer of buffer.
// - Error pending sets on counter status change, held until cleared.
// - Pending word read-only: error bit 15, buffers 14..0.
// - Writing one to error clear bit clears error pending.
// - Each buffer clear bit written one clears its pending flag.
// - Error joins the interrupt code only while its code enable is one.
// - Buffer joins the interrupt code only while its enable is one.
// - Node state codes: 000,010,011,10X passive,11X bus off.
// - Code: flag 0 none, flag 1 src 0 error, 1..15 buffers 0..14.
// - Status word: state 7..5, flag 4, source 3..0, 15..8 zero.
// - Type 0: error pending on every bus error; 1: on state change.
//
// Decided for this implementation: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module cbm_top
   import cbm_pkg::*;
(
   // Clock and reset
   input  wire logic        i_mclk,
   input  wire logic        i_sys_rst,
   // Register port
   input  wire logic [3:0]  i_addr,
   input  wire logic [15:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic [15:0]      o_rdata,
   // Acceptance check request
   input  wire logic        i_acc_req,
   input  wire cbm_frame_t  i_frame,
   input  wire cbm_frame_t  i_buf_id,
   output logic             o_acc_valid,
   output logic             o_acc_match,
   output cbm_frame_t       o_acc_new_id,
   // Events from the protocol engine
   input  wire logic [14:0] i_buf_done,
   input  wire logic        i_bus_error,
   input  wire logic [2:0]  i_node_state,
   // Interrupt requests to the CPU
   output logic             o_err_irq,
   output logic [14:0]      o_buf_irq
);

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   logic [15:0] mask_high_reg;
   logic [15:0] mask_low_reg;
   logic [15:0] int_en_reg;
   logic [15:0] code_en_reg;
   logic        eit_reg;
   logic        err_pend_reg;
   logic        err_pend_next;
   logic [14:0] buf_pend_reg;
   logic [14:0] buf_pend_next;
   logic [2:0]  node_state_reg;
   logic [2:0]  prev_state_reg;
   logic [15:0] rdata_next;
   logic        acc_match_w;
   cbm_frame_t  acc_new_w;
   cbm_status_t status_w;
   logic        err_event;
   logic        clr_wr;

   // Severity class of a node state, for change detection; warning
   // and error active must stay apart or that step raises no event
   function automatic logic [2:0] state_class(input logic [2:0] s);
      if (s[2]) begin
         state_class = s[1] ? 3'h4 : 3'h3;
      end else if (s[1]) begin
         state_class = s[0] ? 3'h2 : 3'h1;
      end else begin
         state_class = 3'h0;
      end
   endfunction

   // Priority encoder: error first, then lowest buffer index
   function automatic logic [4:0] encode(input logic e,
                                         input logic [14:0] b);
      logic [4:0] r;
      r = {1'b0, SRC_NONE};
      if (e) begin
         r = {1'b1, SRC_NONE};
      end else begin
         for (int k = NUM_BUF - 1; k >= 0; k--) begin
            if (b[k]) r = {1'b1, 4'(k + 1)};
         end
      end
      encode = r;
   endfunction

   // ----------------------------------------------------------------
   // Acceptance filter
   // ----------------------------------------------------------------
   cbm_filter u_filter (
      .i_mask_high (mask_high_reg),
      .i_mask_low  (mask_low_reg),
      .i_frame     (i_frame),
      .i_buf       (i_buf_id),
      .o_match     (acc_match_w),
      .o_new_id    (acc_new_w)
   );

   // Filter result registered so outputs come from flip-flops
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         o_acc_valid  <= 1'b0;
         o_acc_match  <= 1'b0;
         o_acc_new_id <= '0;
      end else begin
         o_acc_valid  <= i_acc_req;
         // Result stands until the next request, even if masks change
         if (i_acc_req) begin
            o_acc_match  <= acc_match_w;
            o_acc_new_id <= acc_match_w ? acc_new_w : i_buf_id;
         end
      end
   end

   // ----------------------------------------------------------------
   // Software-written registers
   // ----------------------------------------------------------------
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         mask_high_reg <= RESET_WORD;
         mask_low_reg  <= RESET_WORD;
         int_en_reg    <= RESET_WORD;
         code_en_reg   <= RESET_WORD;
         eit_reg       <= 1'b0;
      end else if (i_wr) begin
         case (i_addr)
            ADDR_MASK_HIGH: mask_high_reg <= i_wdata;
            ADDR_MASK_LOW:  mask_low_reg  <= i_wdata;
            ADDR_INT_EN:    int_en_reg    <= i_wdata;
            ADDR_CODE_EN:   code_en_reg   <= i_wdata;
            ADDR_CONFIG:    eit_reg       <= i_wdata[CFG_EIT_BIT];
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Node state tracking and error event
   // ----------------------------------------------------------------
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         node_state_reg <= NS_NOT_ACTIVE;
         prev_state_reg <= NS_NOT_ACTIVE;
      end else begin
         node_state_reg <= i_node_state;
         prev_state_reg <= node_state_reg;
      end
   end

   // A state change is judged by class so the don't-care bit of the
   // passive and bus-off codes cannot fake an event.
   always_comb begin
      if (eit_reg) begin
         err_event = state_class(node_state_reg)
                     != state_class(prev_state_reg);
      end else begin
         err_event = i_bus_error;
      end
   end

   // ----------------------------------------------------------------
   // Pending flags; a set in the clearing cycle wins
   // ----------------------------------------------------------------
   assign clr_wr = i_wr && (i_addr == ADDR_INT_CLR);

   always_comb begin
      err_pend_next = err_pend_reg;
      buf_pend_next = buf_pend_reg;
      if (clr_wr) begin
         if (i_wdata[ERR_BIT]) err_pend_next = 1'b0;
         buf_pend_next = buf_pend_reg & ~i_wdata[14:0];
      end
      if (err_event) err_pend_next = 1'b1;
      buf_pend_next = buf_pend_next | i_buf_done;
   end

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         err_pend_reg <= 1'b0;
         buf_pend_reg <= 15'h0000;
      end else begin
         err_pend_reg <= err_pend_next;
         buf_pend_reg <= buf_pend_next;
      end
   end

   // ----------------------------------------------------------------
   // Interrupt outputs, gated by the enables
   // ----------------------------------------------------------------
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         o_err_irq <= 1'b0;
         o_buf_irq <= 15'h0000;
      end else begin
         o_err_irq <= err_pend_next & int_en_reg[ERR_BIT];
         o_buf_irq <= buf_pend_next & int_en_reg[14:0];
      end
   end

   // ----------------------------------------------------------------
   // Status word and read port
   // ----------------------------------------------------------------
   always_comb begin
      status_w.rsvd       = 8'h00;
      status_w.node_state = node_state_reg;
      {status_w.irq, status_w.source_code} =
         encode(err_pend_reg & code_en_reg[ERR_BIT],
                buf_pend_reg & code_en_reg[14:0]);
   end

   // The clear register is write-only and reads as zero
   always_comb begin
      case (i_addr)
         ADDR_MASK_HIGH: rdata_next = mask_high_reg;
         ADDR_MASK_LOW:  rdata_next = mask_low_reg;
         ADDR_INT_EN:    rdata_next = int_en_reg;
         ADDR_INT_PEND:  rdata_next = {err_pend_reg, buf_pend_reg};
         ADDR_CODE_EN:   rdata_next = code_en_reg;
         ADDR_STATUS:    rdata_next = status_w;
         ADDR_CONFIG:    rdata_next = {15'h0000, eit_reg};
         default:        rdata_next = RESET_WORD;
      endcase
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         o_rdata <= RESET_WORD;
      end else begin
         o_rdata <= i_rd ? rdata_next : RESET_WORD;
      end
   end

endmodule

// File: cbm_top_chk.sv
// Checker for the register, acceptance and interrupt ports of cbm_top.
// Assumes it is bound into cbm_top and sees only that module's ports.
`timescale 1ns/1ps
module cbm_top_chk
   import cbm_pkg::*;
(
   // Clock, reset and register port
   input wire logic        i_mclk,
   input wire logic        i_sys_rst,
   input wire logic [3:0]  i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic        i_wr,
   input wire logic        i_rd,
   input wire logic [15:0] o_rdata,
   // Acceptance and events
   input wire logic        i_acc_req,
   input wire cbm_frame_t  i_frame,
   input wire cbm_frame_t  i_buf_id,
   input wire logic        o_acc_valid,
   input wire logic        o_acc_match,
   input wire cbm_frame_t  o_acc_new_id,
   input wire logic [14:0] i_buf_done,
   input wire logic        o_err_irq,
   input wire logic [14:0] o_buf_irq
);
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_sys_rst);
   // Shadow of the enable word, so irq gating can be judged at the ports
   logic [15:0] en_reg;
   logic        en_wr;
   assign en_wr = i_wr && (i_addr == ADDR_INT_EN);
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst)
         en_reg <= RESET_WORD;
      else if (en_wr)
         en_reg <= i_wdata;
   end
   // Request and its one-cycle answer
   sequence s_req;
      i_acc_req;
   endsequence
   sequence s_ans;
      o_acc_valid;
   endsequence
   chk_acc_answer: assert property (s_req |=> s_ans)
      else $error("acceptance answer missing");
   chk_acc_quiet: assert property (!i_acc_req |=>
      !o_acc_valid && $stable(o_acc_new_id))
      else $error("acceptance outputs moved without request");
   chk_acc_equal: assert property (i_acc_req && i_frame == i_buf_id
      |=> o_acc_match && o_acc_new_id == $past(i_buf_id))
      else $error("identical header not accepted");
   // The cycle after an enable write may still show the old gate
   chk_buf_gate: assert property (!$past(en_wr) |->
      (o_buf_irq & ~en_reg[14:0]) == 15'h0000)
      else $error("buffer irq without enable");
   chk_err_gate: assert property (!$past(en_wr) && o_err_irq |->
      en_reg[15])
      else $error("error irq without enable");
   chk_buf_set: assert property ((i_buf_done & en_reg[14:0]) != 0
      && !en_wr |=> (o_buf_irq & $past(i_buf_done))
      == ($past(i_buf_done) & en_reg[14:0]))
      else $error("buffer irq not raised after completion");
   chk_rd_idle: assert property (!$past(i_rd) |->
      o_rdata == 16'h0000)
      else $error("read data outside read answer cycle");
   chk_status_rsvd: assert property ($past(i_rd) &&
      $past(i_addr) == ADDR_STATUS |-> o_rdata[15:8] == 8'h00)
      else $error("status reserved bits not zero");
endmodule

bind cbm_top cbm_top_chk i_chk (
   .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
   .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
   .i_acc_req(i_acc_req), .i_frame(i_frame), .i_buf_id(i_buf_id),
   .o_acc_valid(o_acc_valid), .o_acc_match(o_acc_match),
   .o_acc_new_id(o_acc_new_id), .i_buf_done(i_buf_done),
   .o_err_irq(o_err_irq), .o_buf_irq(o_buf_irq));

// File: cbm_eng_model.sv
// Model of the protocol engine that reports transfers and errors.
// Assumes the caller runs its tasks in step with the module clock.
`timescale 1ns/1ps
module cbm_eng_model
   import cbm_pkg::*;
(
   // Clock
   input  wire logic   i_mclk,
   // Events toward the register logic
   output logic [14:0] o_buf_done,
   output logic        o_bus_error,
   output logic [2:0]  o_node_state
);
   // Quiet at time zero; the node starts error active
   initial begin
      o_buf_done = 15'h0000;
      o_bus_error = 1'b0;
      o_node_state = NS_ERR_ACTIVE;
   end
   // One-cycle pulses, so a held level never sets a flag twice
   task automatic pulse(input logic [14:0] d, input logic e);
      @(posedge i_mclk);
      o_buf_done <= d;
      o_bus_error <= e;
      @(posedge i_mclk);
      o_buf_done <= 15'h0000;
      o_bus_error <= 1'b0;
   endtask
   // Node state moves after an error counter update
   task automatic set_state(input logic [2:0] s);
      @(posedge i_mclk);
      o_node_state <= s;
   endtask
endmodule

// File: cbm_top_bench.sv
// Testbench for cbm_top: registers, acceptance and interrupt events.
// Assumes the checker binds itself and the engine model drives events.
`timescale 1ns/1ps
module cbm_top_bench;
   import cbm_pkg::*;
   logic        i_mclk = 0, i_sys_rst = 1, i_wr = 0, i_rd = 0;
   logic        i_acc_req = 0, o_acc_valid, o_acc_match, o_err_irq;
   logic [3:0]  i_addr = 0;
   logic [15:0] i_wdata = 0, o_rdata;
   logic [14:0] done, o_buf_irq;
   logic        berr;
   logic [2:0]  nstate;
   cbm_frame_t  i_frame = '0, i_buf_id = '0, o_acc_new_id;
   cbm_frame_t  fs, fs2, fx, bz, bx;
   int          num_errors = 0, checks_done = 0;
   logic [2:0]  states [5] = '{3'h3, 3'h4, 3'h6, 3'h0, 3'h2};

   always #50 i_mclk = ~i_mclk;

   cbm_eng_model i_eng (.i_mclk(i_mclk), .o_buf_done(done),
      .o_bus_error(berr), .o_node_state(nstate));
   cbm_top i_dut (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
      .o_rdata(o_rdata), .i_acc_req(i_acc_req), .i_frame(i_frame),
      .i_buf_id(i_buf_id), .o_acc_valid(o_acc_valid),
      .o_acc_match(o_acc_match), .o_acc_new_id(o_acc_new_id),
      .i_buf_done(done), .i_bus_error(berr), .i_node_state(nstate),
      .o_err_irq(o_err_irq), .o_buf_irq(o_buf_irq));

   // Compare and count; case inequality so unknowns never pass
   task automatic check(string what, logic [39:0] seen, logic [39:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(logic [3:0] a, logic [15:0] d);
      @(posedge i_mclk);
      i_wr <= 1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_mclk);
      i_wr <= 0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd(logic [3:0] a, logic [15:0] e);
      @(posedge i_mclk);
      i_rd <= 1;
      i_addr <= a;
      @(posedge i_mclk);
      i_rd <= 0;
      #1 check($sformatf("rdata at %0d", a), o_rdata, e);
   endtask
   task automatic acc(cbm_frame_t f, cbm_frame_t b, logic m, cbm_frame_t n);
      @(posedge i_mclk);
      i_acc_req <= 1;
      i_frame <= f;
      i_buf_id <= b;
      @(posedge i_mclk);
      i_acc_req <= 0;
      #1 check("acc valid", o_acc_valid, 1'b1);
      check("acc match", o_acc_match, m);
      check("acc new id", o_acc_new_id, n);
   endtask
   task complete_run;
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial begin
      fs = '0; fs.id[18] = 1; fs2 = '0; fs2.id[0] = 1; bz = '0;
      fx = '0; fx.ext = 1; fx.id[0] = 1; fx.srr_rtr = 1; fx.ext_remote_mask = 1;
      bx = '0; bx.ext = 1;
      repeat (3) @(posedge i_mclk);
      i_sys_rst <= 0;
      for (int a = 0; a < 9; a++)
         rd(a[3:0], (a == 6) ? 16'h0040 : 16'h0000);
      $display("test reset done");
      wr(ADDR_MASK_HIGH, 16'hFFFF);
      rd(ADDR_MASK_HIGH, 16'hFFFF);
      wr(ADDR_MASK_HIGH, 16'h0000);
      acc(fs, bz, 0, bz);
      acc(fs2, bz, 1, bz);
      acc(fx, bx, 0, bx);
      wr(ADDR_MASK_HIGH, 16'h0020);
      acc(fs, bz, 1, fs);
      wr(ADDR_MASK_HIGH, 16'h0010);
      acc(fx, bx, 0, bx);
      wr(ADDR_MASK_LOW, 16'h0003);
      acc(fx, bx, 1, fx);
      rd(ADDR_MASK_LOW, 16'h0003);
      $display("test mask done");
      wr(ADDR_INT_EN, 16'h8005);
      i_eng.pulse(15'h0007, 0);
      rd(ADDR_INT_PEND, 16'h0007);
      check("buf irq", o_buf_irq, 15'h0005);
      rd(ADDR_STATUS, 16'h0040);
      wr(ADDR_CODE_EN, 16'h0006);
      rd(ADDR_STATUS, 16'h0052);
      wr(ADDR_INT_CLR, 16'h0002);
      rd(ADDR_INT_PEND, 16'h0005);
      rd(ADDR_STATUS, 16'h0053);
      wr(ADDR_INT_PEND, 16'hFFFF);
      rd(ADDR_INT_PEND, 16'h0005);
      i_eng.pulse(15'h0000, 1);
      rd(ADDR_INT_PEND, 16'h8005);
      check("err irq", o_err_irq, 1'b1);
      wr(ADDR_CODE_EN, 16'h8006);
      rd(ADDR_STATUS, 16'h0050);
      wr(ADDR_INT_EN, 16'h0005);
      @(posedge i_mclk);
      #1 check("err irq off", o_err_irq, 1'b0);
      wr(ADDR_INT_CLR, 16'h0001);
      rd(ADDR_INT_PEND, 16'h8004);
      wr(ADDR_INT_CLR, 16'h8000);
      rd(ADDR_INT_PEND, 16'h0004);
      $display("test interrupt done");
      wr(ADDR_CONFIG, 16'h0001);
      i_eng.pulse(15'h0000, 1);
      rd(ADDR_INT_PEND, 16'h0004);
      foreach (states[k]) begin
         i_eng.set_state(states[k]);
         repeat (4) @(posedge i_mclk);
         rd(ADDR_STATUS, {8'h00, states[k], 5'h10});
         rd(ADDR_INT_PEND, 16'h8004);
         wr(ADDR_INT_CLR, 16'h8000);
      end
      $display("test node state done");
      complete_run();
   end
endmodule
